// ### core/pulse_rate_dac_generator.v
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pwm_brm_map.vh"

module pulse_rate_dac_generator #(
    parameter CHANNELS = `CHANNELS
) (
    clk,
    rstn,
    awaddr,
    awvalid,
    awready,
    wdata,
    wstrb,
    wvalid,
    wready,
    bresp,
    bvalid,
    bready,
    araddr,
    arvalid,
    arready,
    rdata,
    rresp,
    rvalid,
    rready,
    pwm_out
);
    input wire clk; // system clock
    input wire rstn; // async reset, active low
    input wire [`ADDR_W-1:0] awaddr; // write address
    input wire awvalid; // write address valid
    output reg awready; // write address taken
    input wire [31:0] wdata; // write data
    input wire [3:0] wstrb; // write byte lanes
    input wire wvalid; // write data valid
    output reg wready; // write data taken
    output reg [1:0] bresp; // write answer code
    output reg bvalid; // write answer valid
    input wire bready; // master takes write answer
    input wire [`ADDR_W-1:0] araddr; // read address
    input wire arvalid; // read address valid
    output reg arready; // read address taken
    output reg [31:0] rdata; // read data
    output reg [1:0] rresp; // read answer code
    output reg rvalid; // read answer valid
    input wire rready; // master takes read answer
    output wire [CHANNELS-1:0] pwm_out; // channel pins, from flops

    // per-channel field width inside the weight bank
    localparam SLOT_W = `WEIGHT_W + 1;

    // shared counter value
    wire [`CNT_W-1:0] count;

    // weight bank: invert bit above weight, per channel
    reg [4*SLOT_W-1:0] weight_bank_reg;
    // fine-tune bank: {ch3_ch2, ch1_ch0}, channel c at 4c
    reg [15:0] fine_bank_reg;

    // write side holding registers
    reg aw_have_reg; // address captured
    reg w_have_reg; // data captured
    reg [`ADDR_W-1:0] aw_addr_reg; // captured write address
    reg [7:0] w_byte_reg; // captured low data byte
    reg w_lane_reg; // low byte lane enabled

    // read side holding registers
    reg ar_have_reg; // address captured
    reg [`ADDR_W-1:0] ar_addr_reg; // captured read address

    // write commit and decode
    wire wr_commit; // both halves present, answer free
    wire [`IDX_W-1:0] wr_index; // register index of write
    reg wr_mapped; // write hits a writable register

    // read decode
    wire [`IDX_W-1:0] rd_index; // register index of read
    reg [31:0] rd_value; // value of addressed register
    reg rd_mapped; // read hits a register

    assign wr_commit = aw_have_reg & w_have_reg & ~bvalid;
    assign wr_index = aw_addr_reg[`ADDR_W-1:2];
    assign rd_index = ar_addr_reg[`ADDR_W-1:2];

    // one counter feeds every channel
    free_counter #(
        .CNT_W(`CNT_W)
    ) u_counter (
        .clk(clk),
        .rstn(rstn),
        .count(count)
    );

    // one waveform slice per channel, each on its own pin
    // storage stays four wide whatever CHANNELS is
    genvar c;
    generate
        for (c = 0; c < CHANNELS; c = c + 1) begin : g_chan
            pwm_channel u_chan (
                .clk(clk),
                .rstn(rstn),
                .count(count),
                .weight(weight_bank_reg[c*SLOT_W +: `WEIGHT_W]),
                .fine(fine_bank_reg[c*`FINE_W +: `FINE_W]),
                .output_invert(weight_bank_reg[c*SLOT_W + `WEIGHT_W]),
                .pin(pwm_out[c])
            );
        end
    endgenerate

    // write decode: which indexes accept a write
    always @* begin
        case (wr_index)
            `IDX_WEIGHT0: begin
                wr_mapped = 1'b1;
            end
            `IDX_WEIGHT1: begin
                wr_mapped = 1'b1;
            end
            `IDX_WEIGHT2: begin
                wr_mapped = 1'b1;
            end
            `IDX_WEIGHT3: begin
                wr_mapped = 1'b1;
            end
            `IDX_FINE10: begin
                wr_mapped = 1'b1;
            end
            `IDX_FINE32: begin
                wr_mapped = 1'b1;
            end
            default: begin
                // counter readback and unmapped: refused
                wr_mapped = 1'b0;
            end
        endcase
    end

    // read mux: fixed bit 7 reads one, bits above 7 zero except counter bits 9:8
    always @* begin
        // defaults: zero data, answer okay
        rd_value = 32'h0000_0000;
        rd_mapped = 1'b1;
        case (rd_index)
            `IDX_WEIGHT0: begin
                rd_value[7:0] = {1'b1, weight_bank_reg[0*SLOT_W +: SLOT_W]};
            end
            `IDX_WEIGHT1: begin
                rd_value[7:0] = {1'b1, weight_bank_reg[1*SLOT_W +: SLOT_W]};
            end
            `IDX_WEIGHT2: begin
                rd_value[7:0] = {1'b1, weight_bank_reg[2*SLOT_W +: SLOT_W]};
            end
            `IDX_WEIGHT3: begin
                rd_value[7:0] = {1'b1, weight_bank_reg[3*SLOT_W +: SLOT_W]};
            end
            `IDX_FINE10: begin
                rd_value[7:0] = fine_bank_reg[7:0];
            end
            `IDX_FINE32: begin
                rd_value[7:0] = fine_bank_reg[15:8];
            end
            `IDX_COUNT: begin
                // live shared counter
                rd_value[`CNT_W-1:0] = count;
            end
            default: begin
                // unmapped: zero data, error answer
                rd_mapped = 1'b0;
            end
        endcase
    end

    // register bank writes; only the low lane carries data
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            // weight bits reset to zero, fixed bit is not stored
            weight_bank_reg <= {(4*SLOT_W){1'b0}};
            fine_bank_reg <= {`FINE_RESET, `FINE_RESET};
        end else if (wr_commit && wr_mapped && w_lane_reg) begin
            // lane 0 off: answered okay, nothing stored
            case (wr_index)
                `IDX_WEIGHT0: begin
                    // bit 7 dropped, it always reads one
                    weight_bank_reg[0*SLOT_W +: SLOT_W] <= w_byte_reg[SLOT_W-1:0];
                end
                `IDX_WEIGHT1: begin
                    weight_bank_reg[1*SLOT_W +: SLOT_W] <= w_byte_reg[SLOT_W-1:0];
                end
                `IDX_WEIGHT2: begin
                    weight_bank_reg[2*SLOT_W +: SLOT_W] <= w_byte_reg[SLOT_W-1:0];
                end
                `IDX_WEIGHT3: begin
                    weight_bank_reg[3*SLOT_W +: SLOT_W] <= w_byte_reg[SLOT_W-1:0];
                end
                `IDX_FINE10: begin
                    // high nibble channel 1, low nibble channel 0
                    fine_bank_reg[7:0] <= w_byte_reg;
                end
                `IDX_FINE32: begin
                    // high nibble channel 3, low nibble channel 2
                    fine_bank_reg[15:8] <= w_byte_reg;
                end
                default: begin
                    // nothing stored
                    fine_bank_reg <= fine_bank_reg;
                end
            endcase
        end
    end

    // write channel: address and data in either order
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_reg <= 1'b0;
            w_have_reg <= 1'b0;
            aw_addr_reg <= {`ADDR_W{1'b0}};
            w_byte_reg <= 8'h00;
            w_lane_reg <= 1'b0;
            bvalid <= 1'b0;
            bresp <= `RESP_OKAY;
        end else begin
            // capture address, then stop taking more
            if (awvalid && awready) begin
                aw_addr_reg <= awaddr;
                aw_have_reg <= 1'b1;
                awready <= 1'b0;
            end
            // capture data byte and its lane
            if (wvalid && wready) begin
                w_byte_reg <= wdata[7:0];
                w_lane_reg <= wstrb[0];
                w_have_reg <= 1'b1;
                wready <= 1'b0;
            end
            // both present: store and answer
            if (wr_commit) begin
                aw_have_reg <= 1'b0;
                w_have_reg <= 1'b0;
                bvalid <= 1'b1;
                // holes and the read-only counter are refused
                bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            // answer taken: open both channels again
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // read channel: one read at a time, answer two clocks after the take
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            arready <= 1'b1;
            ar_have_reg <= 1'b0;
            ar_addr_reg <= {`ADDR_W{1'b0}};
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= `RESP_OKAY;
        end else begin
            // capture address
            if (arvalid && arready) begin
                ar_addr_reg <= araddr;
                ar_have_reg <= 1'b1;
                arready <= 1'b0;
            end
            // present the addressed value
            if (ar_have_reg && !rvalid) begin
                ar_have_reg <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_value;
                // holes answer an error with zero data
                rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
            end
            // answer taken: accept the next address
            if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end
endmodule

// ### core/pwm_brm_map.vh
`ifndef PWM_BRM_MAP_VH
`define PWM_BRM_MAP_VH

// widths of the shared counter and its fields
`define CNT_W 10
`define WEIGHT_W 6
`define FINE_W 4
`define PERIOD_W 4
`define CHANNELS 4

// register indexes; byte address is index times four
`define IDX_W 10
`define IDX_WEIGHT0 10'h074
`define IDX_FINE10 10'h075
`define IDX_WEIGHT1 10'h076
`define IDX_WEIGHT2 10'h077
`define IDX_FINE32 10'h078
`define IDX_WEIGHT3 10'h079
`define IDX_COUNT 10'h07a
`define ADDR_W 12

// weight register fields
`define WEIGHT_FIXED_BIT 7
`define INVERT_BIT 6
`define WEIGHT_RESET 8'h80
`define FINE_RESET 8'h00

// fine-tune period selection patterns
`define SEL_EIGHT_PERIOD 4'h8
`define SEL_FOUR_PHASE 3'h4
`define SEL_TWO_PHASE 2'h2

// bus answers
`define RESP_OKAY 2'b00
`define RESP_SLVERR 2'b10

`endif

// ### core/free_counter.v
`timescale 1ns/1ps
`include "pwm_brm_map.vh"

// shared free-running counter, never stops
module free_counter #(
    parameter CNT_W = `CNT_W
) (
    clk,
    rstn,
    count
);
    input wire clk; // system clock
    input wire rstn; // async reset, active low
    output reg [CNT_W-1:0] count; // current count

    // increment on every clock, wrap naturally
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            count <= {CNT_W{1'b0}};
        end else begin
            count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
        end
    end
endmodule

// ### core/pwm_channel.v
`timescale 1ns/1ps
`include "pwm_brm_map.vh"

// one output channel: coarse pulse plus fine widening
module pwm_channel (
    clk,
    rstn,
    count,
    weight,
    fine,
    output_invert,
    pin
);
    input wire clk; // system clock
    input wire rstn; // async reset, active low
    input wire [`CNT_W-1:0] count; // shared counter value
    input wire [`WEIGHT_W-1:0] weight; // coarse pulse weight
    input wire [`FINE_W-1:0] fine; // fine-tune selection bits
    input wire output_invert; // swap output levels
    output reg pin; // channel output pin

    // split the shared count into phase and period
    wire [`WEIGHT_W-1:0] phase; // low bits, pulse counter
    wire [`PERIOD_W-1:0] period; // high bits, period index
    wire widen; // this period gets one extra clock
    wire active; // pulse level before inversion

    assign phase = count[`WEIGHT_W-1:0];
    assign period = count[`CNT_W-1:`WEIGHT_W];

    // selections add; period 0 never matches any term
    assign widen = (fine[0] & (period == `SEL_EIGHT_PERIOD))
        | (fine[1] & (period[2:0] == `SEL_FOUR_PHASE))
        | (fine[2] & (period[1:0] == `SEL_TWO_PHASE))
        | (fine[3] & period[0]);

    // set at phase rollover, cleared when phase meets weight
    // widening keeps the pulse one clock longer at its end, through phase equal to weight
    assign active = widen ? (phase <= weight) : (phase < weight);

    // registered pin, low during and after reset
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin <= 1'b0;
        end else begin
            pin <= active ^ output_invert;
        end
    end
endmodule

// ### bench/rc_filter_model.sv
`timescale 1ns/1ps

// rc network at the pins, seen as an integrator of high time
module rc_filter_model (
    clk,
    clr,
    pins,
    level
);
    input wire clk; // system clock
    input wire clr; // empties the integrators
    input wire [3:0] pins; // channel pins
    output logic [3:0][10:0] level; // high clocks since clear
    // integrate every pin each clock
    always @(posedge clk) begin
        for (int c = 0; c < 4; c++) begin
            level[c] <= clr ? 11'h000 : level[c] + 11'(pins[c]);
        end
    end
endmodule

// ### bench/pulse_rate_dac_generator_sva.sv
`timescale 1ns/1ps
`include "pwm_brm_map.vh"

module pulse_rate_dac_generator_sva #(
    parameter CHANNELS = 4
) (
    input logic clk,
    input logic rstn,
    input logic [11:0] awaddr,
    input logic awvalid,
    input logic awready,
    input logic [31:0] wdata,
    input logic [3:0] wstrb,
    input logic wvalid,
    input logic wready,
    input logic [1:0] bresp,
    input logic bvalid,
    input logic bready,
    input logic [11:0] araddr,
    input logic arvalid,
    input logic arready,
    input logic [31:0] rdata,
    input logic [1:0] rresp,
    input logic rvalid,
    input logic rready,
    input logic [CHANNELS-1:0] pwm_out
);
    logic [9:0] ra_reg; // index of the read in flight
    // remember the read index at its take
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ra_reg <= 10'h000;
        end else if (arvalid && arready) begin
            ra_reg <= araddr[11:2];
        end
    end
    wire is_w = ra_reg == `IDX_WEIGHT0 || ra_reg == `IDX_WEIGHT1 ||
        ra_reg == `IDX_WEIGHT2 || ra_reg == `IDX_WEIGHT3; // weight read
    wire is_f = ra_reg == `IDX_FINE10 || ra_reg == `IDX_FINE32; // fine read
    wire ok = rresp == `RESP_OKAY; // read accepted
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    chk_write_answer: assert property (awvalid && awready && wvalid && wready
        |=> !bvalid ##1 bvalid) else $error("write answer off time");
    chk_read_answer: assert property (arvalid && arready |=> !rvalid ##1 rvalid)
        else $error("read answer off time");
    chk_aw_blocked: assert property (bvalid |-> !awready && !wready)
        else $error("write taken while answer pending");
    chk_ar_blocked: assert property (rvalid |-> !arready)
        else $error("read taken while answer pending");
    chk_ready_back: assert property (bvalid && bready |=> !bvalid && awready && wready)
        else $error("write channel not freed");
    chk_read_done: assert property (rvalid && rready |=> !rvalid && arready)
        else $error("read channel not freed");
    chk_reset_pins: assert property ($rose(rstn) |-> pwm_out == '0)
        else $error("pins not low after reset");
    chk_fixed_bit: assert property (rvalid && ok && is_w |-> rdata[31:7] == 25'h1)
        else $error("weight top bit wrong");
    chk_fine_width: assert property (rvalid && ok && is_f |-> rdata[31:8] == 24'h0)
        else $error("fine register too wide");
    chk_err_zero: assert property (rvalid && !ok |-> rdata == 32'h0)
        else $error("refused read carries data");
endmodule

bind pulse_rate_dac_generator pulse_rate_dac_generator_sva #(.CHANNELS(CHANNELS)) chk (
    .clk(clk), .rstn(rstn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
    .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .pwm_out(pwm_out));

// ### bench/test_pulse_rate_dac_generator.sv
`timescale 1ns/1ps
`include "pwm_brm_map.vh"
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin bad_count++; \
    $display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (e)); end end

module test_pulse_rate_dac_generator;
    logic clk = 0;
    logic rstn = 0;
    logic [11:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] wstrb = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, clr = 0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [3:0] pwm_out;
    wire [3:0][10:0] level; // high time per pin
    int bad_count = 0, compares = 0, cyc = 0, t1, t2;
    logic [31:0] rd, rd2;
    logic [1:0] rs;
    localparam logic [9:0] regs[6] = '{`IDX_WEIGHT0, `IDX_FINE10, `IDX_WEIGHT1,
        `IDX_WEIGHT2, `IDX_FINE32, `IDX_WEIGHT3};
    localparam logic [9:0] widx[4] = '{`IDX_WEIGHT0, `IDX_WEIGHT1, `IDX_WEIGHT2, `IDX_WEIGHT3};
    // cases: weight, fine, invert
    localparam logic [5:0] cw[8] = '{6'h18, 6'h00, 6'h3f, 6'h00, 6'h18, 6'h18, 6'h18, 6'h05};
    localparam logic [3:0] cf[8] = '{4'h6, 4'h0, 4'hf, 4'h0, 4'h1, 4'h2, 4'h8, 4'h4};
    localparam logic ci[8] = '{1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1};

    initial forever #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;

    pulse_rate_dac_generator dut (.clk(clk), .rstn(rstn), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb),
        .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata),
        .rresp(rresp), .rvalid(rvalid), .rready(rready), .pwm_out(pwm_out));
    rc_filter_model rc (.clk(clk), .clr(clr), .pins(pwm_out), .level(level));

    task automatic end_sim;
        $display("compares=%0d bad_count=%0d", compares, bad_count);
        if (bad_count == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // one write; holds bready until the answer
    task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [3:0] s);
        int n;
        n = 0;
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h0, d};
        wstrb <= s;
        awvalid <= 1;
        wvalid <= 1;
        bready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid && n < 100);
        rs = bresp;
        bready <= 0;
        if (!bvalid) begin
            bad_count++;
            end_sim();
        end
    endtask

    // one read; tc is the cycle of the take
    task automatic rd_t(input logic [9:0] idx, output logic [31:0] d, output int tc);
        int n;
        n = 0;
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1;
        rready <= 1;
        do begin
            @(posedge clk);
            n++;
            if (arready && arvalid) begin
                arvalid <= 0;
                tc = cyc;
            end
        end while (!rvalid && n < 100);
        d = rdata;
        rs = rresp;
        rready <= 0;
        if (!rvalid) begin
            bad_count++;
            end_sim();
        end
    endtask

    // fine-tune selection of one period, period 0 never
    function automatic logic sel(logic [3:0] f, int p);
        return (f[0] && p == 8) || (f[1] && p % 8 == 4) || (f[2] && p % 4 == 2) ||
            (f[3] && p % 2 == 1);
    endfunction

    // high clocks per 1024-clock frame
    function automatic logic [10:0] exp_high(logic [5:0] w, logic [3:0] f, logic inv);
        int n;
        n = 16 * w;
        for (int p = 1; p < 16; p++) begin
            n += sel(f, p);
        end
        return inv ? 11'(1024 - n) : 11'(n);
    endfunction

    task automatic t_reset;
        `CHK(pwm_out, 4'h0)
        for (int i = 0; i < 6; i++) begin
            rd_t(regs[i], rd, t1);
            `CHK(rd, ((i == 1 || i == 4) ? 32'h0 : 32'h80))
        end
        rd_t(10'h000, rd, t1);
        `CHK({rs, rd}, {`RESP_SLVERR, 32'h0})
    endtask

    task automatic t_fields;
        wr(`IDX_WEIGHT1, 8'h7f, 4'h1);
        rd_t(`IDX_WEIGHT1, rd, t1);
        `CHK(rd, 32'hff)
        wr(`IDX_WEIGHT1, 8'h00, 4'h0);
        rd_t(`IDX_WEIGHT1, rd, t1);
        `CHK(rd, 32'hff)
        wr(`IDX_COUNT, 8'h00, 4'h1);
        `CHK(rs, `RESP_SLVERR)
        wr(`IDX_FINE32, 8'ha5, 4'h1);
        rd_t(`IDX_FINE32, rd, t1);
        `CHK(rd, 32'ha5)
    endtask

    // counter advances once per clock
    task automatic t_counter;
        rd_t(`IDX_COUNT, rd, t1);
        repeat (37) @(posedge clk);
        rd_t(`IDX_COUNT, rd2, t2);
        `CHK(rd2[9:0], rd[9:0] + 10'(t2 - t1))
    endtask

    // four cases at once, shared fine registers
    task automatic t_duty(input int r);
        logic [10:0] ex;
        for (int c = 0; c < 4; c++) begin
            wr(widx[c], {1'b0, ci[4 * r + c], cw[4 * r + c]}, 4'h1);
        end
        wr(`IDX_FINE10, {cf[4 * r + 1], cf[4 * r]}, 4'h1);
        wr(`IDX_FINE32, {cf[4 * r + 3], cf[4 * r + 2]}, 4'h1);
        repeat (2) @(posedge clk);
        clr <= 1;
        @(posedge clk);
        clr <= 0;
        repeat (1024) @(posedge clk);
        #1;
        for (int c = 0; c < 4; c++) begin
            ex = exp_high(cw[4*r+c], cf[4*r+c], ci[4*r+c]);
            `CHK(level[c], ex)
        end
    endtask

    // pin by pin over one frame, aligned on the counter readback
    task automatic t_shape(input int r);
        logic [9:0] v;
        logic [3:0] e;
        rd_t(`IDX_COUNT, rd, t1);
        v = rd[9:0];
        repeat (1024) begin
            #1;
            v = v + 10'h001;
            for (int c = 0; c < 4; c++) begin
                e[c] = (int'(v[5:0]) < cw[4*r+c] + sel(cf[4*r+c], int'(v[9:6]))) ^ ci[4*r+c];
            end
            `CHK(pwm_out, e)
            @(posedge clk);
        end
    endtask

    // reset in mid-run drops a high pin and restores the banks
    task automatic t_midreset;
        wr(`IDX_WEIGHT0, 8'h40, 4'h1);
        wr(`IDX_FINE10, 8'h00, 4'h1);
        @(posedge clk);
        #1;
        `CHK(pwm_out[0], 1'b1)
        @(posedge clk);
        rstn <= 0;
        #1;
        `CHK(pwm_out, 4'h0)
        repeat (2) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        `CHK(pwm_out, 4'h0)
        rd_t(`IDX_WEIGHT0, rd, t1);
        `CHK(rd, 32'h80)
        rd_t(`IDX_FINE32, rd, t1);
        `CHK(rd, 32'h0)
    endtask

    // main sequence
    initial begin
        repeat (4) @(posedge clk);
        rstn <= 1;
        @(posedge clk);
        t_reset();
        t_fields();
        t_counter();
        t_duty(0);
        t_shape(0);
        t_duty(1);
        t_shape(1);
        t_midreset();
        end_sim();
    end
endmodule
